//--- verilog/standby_break_reset_status_defs.vh
// Constants for the standby, break and reset-status unit.
`ifndef STANDBY_BREAK_RESET_STATUS_DEFS_VH
`define STANDBY_BREAK_RESET_STATUS_DEFS_VH

// =============================================================
// Register indices (byte address is four times the index)
`define IDX_BREAK_STATUS        16'hfe00
`define IDX_RESET_CAUSE         16'hfe01
`define IDX_BREAK_FLAG_CONTROL  16'hfe03
`define IDX_CONV_PENDING        16'hfe06

// =============================================================
// Field positions
`define BIT_BREAK_IN_STANDBY    1
`define BIT_BREAK_CLEAR_ENABLE  7
`define BIT_CONVERT_DONE        0
`define BIT_POWER_ON            7
`define BIT_PIN                 6
`define BIT_WATCHDOG            5
`define BIT_BAD_OPCODE          4
`define BIT_BAD_ADDRESS         3
`define BIT_MONITOR_ENTRY       2
`define BIT_LOW_VOLTAGE         1

// =============================================================
// Reset values
`define RST_BREAK_STATUS        8'h00
`define RST_RESET_CAUSE         8'h00
`define RST_BREAK_FLAG_CONTROL  8'h00

// =============================================================
// Stop recovery timing, in quad-rate oscillator cycles
`define STOP_RECOVERY_LONG_CYC  4096
`define STOP_RECOVERY_SHORT_CYC 32
`define QUAD_CYC_PER_BUS_CYC    4
`define MONITOR_VECTOR_ONES     16'hffff

`endif

//--- verilog/standby_break_reset_status.v
// Reset priority, break state, flag protection, wait and stop control with APB registers.
// Contract
// R1: Convert-done pending bit live; other bits zero.
// R2: All reset sources equal, above interrupts.
// R3: Break request forces software trap vector.
// R4: In break, flag clears need clear enable.
// R5: Flags cleared in break stay cleared.
// R6: Two-step clears protected; second step later clears.
// R7: Wait or stop clears global interrupt mask.
// R8: Wait gates CPU clock, peripherals keep running.
// R9: Enabled module interrupt wakes CPU from wait.
// R10: Wait wake stacking starts one cycle later.
// R11: Standby exit is reset pin, interrupt, break.
// R12: Break during wait sets break-in-standby flag.
// R13: Watchdog enabled unless disabled, runs in wait.
// R14: Stop resets counter, disables both oscillator clocks.
// R15: Interrupt, reset or break ends stop mode.
// R16: Recovery is 4096 or 32 quad cycles.
// R17: Counter held in stop, then times recovery.
// R18: Crystal systems should keep short recovery off.
// R19: Reset cause flags per source, power-on clears others.
// R20: Reading cause register clears; power-on sets flag.
// R21: Monitor entry flag on erased vector, high pin.
// R22: Decode break status, reset cause, flag control.
`timescale 1ns/1ps
`default_nettype none
`include "standby_break_reset_status_defs.vh"

module standby_break_reset_status #(
  parameter LONG_RECOVERY_CYC  = `STOP_RECOVERY_LONG_CYC,
  parameter SHORT_RECOVERY_CYC = `STOP_RECOVERY_SHORT_CYC
) (
  input  wire        clock_i,
  input  wire        arst_n_i,
  // APB slave.
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // Reset sources, synchronous levels.
  input  wire        power_on_i,
  input  wire        pin_reset_i,
  input  wire        watchdog_reset_i,
  input  wire        bad_opcode_i,
  input  wire        bad_address_i,
  input  wire        low_voltage_i,
  input  wire [15:0] reset_vector_i,
  input  wire        irq_pin_at_supply_i,
  // CPU and module events.
  input  wire        break_req_i,
  input  wire        break_exit_i,
  input  wire        wait_exec_i,
  input  wire        stop_exec_i,
  input  wire        module_irq_i,
  input  wire        convert_done_req_i,
  input  wire        watchdog_disable_i,
  input  wire        short_stop_recovery_i,
  // Control outputs.
  output wire        core_reset_o,
  output wire        force_trap_o,
  output wire        break_state_o,
  output wire        flag_clear_allow_o,
  output wire        clear_imask_o,
  output wire        cpu_clk_en_o,
  output wire        periph_clk_en_o,
  output wire        bus_clock_double_en_o,
  output wire        bus_clock_quad_en_o,
  output wire        counter_hold_o,
  output wire        stack_start_o,
  output wire        watchdog_run_o
);

  // =============================================================
  // Standby states
  localparam [1:0] ST_RUN     = 2'b00;
  localparam [1:0] ST_WAIT    = 2'b01;
  localparam [1:0] ST_STOP    = 2'b10;
  localparam [1:0] ST_RECOVER = 2'b11;
  // Full-width copies, cut on purpose to the 13-bit counter, which
  // holds the longest delay of 4096 quad cycles with room to spare.
  localparam [31:0] LONG_FULL  = LONG_RECOVERY_CYC;
  localparam [31:0] SHORT_FULL = SHORT_RECOVERY_CYC;
  localparam [31:0] QUAD_FULL  = `QUAD_CYC_PER_BUS_CYC;
  localparam [12:0] LONG_CNT   = LONG_FULL[12:0];
  localparam [12:0] SHORT_CNT  = SHORT_FULL[12:0];
  localparam [12:0] QUAD_STEP  = QUAD_FULL[12:0];

  // Index match for a word-aligned APB address.
  // Each register owns one aligned word at four times its index, so
  // a set upper bit or a byte offset misses every register.
  function hit;
    input [31:0] addr;
    input [15:0] idx;
    begin
      hit = (addr[1:0] == 2'b00) && (addr[31:18] == 14'h0000) && (addr[17:2] == idx);
    end
  endfunction

  reg  [1:0]  state_reg;
  reg  [12:0] sic_count_reg;
  reg         break_in_standby_reg;
  reg         break_clear_enable_reg;
  reg  [7:0]  reset_cause_reg;
  reg         break_state_reg;
  reg         break_req_d_reg;
  reg         mon_check_reg;
  reg         mon_reset_reg;
  reg         core_reset_reg;
  reg         force_trap_reg;
  reg         clear_imask_reg;
  reg         stack_start_reg;
  reg         stack_after_rec_reg;
  reg  [31:0] prdata_reg;
  reg         pready_reg;
  reg         pslverr_reg;
  reg         cpu_clk_en_reg;
  reg         periph_clk_en_reg;
  reg         osc_en_reg;
  reg         counter_hold_reg;
  reg         watchdog_run_reg;

  wire        any_reset;
  wire        standby_exit;
  wire        break_rise;
  wire        setup_phase;
  wire        access_done;
  wire        mapped;
  wire [12:0] recovery_limit;
  wire [7:0]  cause_set;
  reg  [1:0]  state_next;
  reg  [7:0]  read_byte;

  // =============================================================
  // Event decode
  // Every reset source acts alike; no arbitration among them.
  // A reset pin level also counts as a standby exit, but the reset
  // term that gates the stacking strobe wins, so it raises no stacking.
  assign any_reset    = power_on_i | pin_reset_i | watchdog_reset_i | bad_opcode_i |
                        bad_address_i | low_voltage_i | mon_reset_reg; // R2
  assign standby_exit = pin_reset_i | module_irq_i | break_req_i; // R11
  assign break_rise   = break_req_i & ~break_req_d_reg;
  assign recovery_limit = short_stop_recovery_i ? SHORT_CNT : LONG_CNT; // R16
  assign setup_phase  = psel_i & ~penable_i;
  assign access_done  = psel_i & penable_i & pready_reg;
  assign mapped       = hit(paddr_i, `IDX_BREAK_STATUS) | hit(paddr_i, `IDX_RESET_CAUSE) |
                        hit(paddr_i, `IDX_BREAK_FLAG_CONTROL) | hit(paddr_i, `IDX_CONV_PENDING); // R22

  // Flags for the causes present at this cycle.
  assign cause_set = {power_on_i, pin_reset_i, watchdog_reset_i, bad_opcode_i,
                      bad_address_i, mon_reset_reg, low_voltage_i, 1'b0}; // R19

  // =============================================================
  // Read multiplexer
  // Read data for the addressed register; reserved bits read zero.
  // The mux sees the address in the setup cycle, so the word is
  // captured one cycle before the access phase that returns it.
  // Converter pending is a live copy of the request, never latched.
  always @*
  begin
    read_byte = 8'h00;
    if (hit(paddr_i, `IDX_BREAK_STATUS))
      read_byte[`BIT_BREAK_IN_STANDBY] = break_in_standby_reg;
    else if (hit(paddr_i, `IDX_RESET_CAUSE))
      read_byte = reset_cause_reg;
    else if (hit(paddr_i, `IDX_BREAK_FLAG_CONTROL))
      read_byte[`BIT_BREAK_CLEAR_ENABLE] = break_clear_enable_reg;
    else if (hit(paddr_i, `IDX_CONV_PENDING))
      read_byte[`BIT_CONVERT_DONE] = convert_done_req_i; // R1
  end

  // =============================================================
  // Standby state machine
  // Next state; any reset returns to run ahead of interrupts.
  // Run accepts wait or stop; stop wins if both strobes arrive at once.
  // Wait returns to run on any standby exit, with no delay.
  // Stop moves to recovery on an interrupt or break; the oscillator
  // needs the recovery time before the core may fetch again.
  // Recovery ends when the counter reaches the selected limit.
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (stop_exec_i)
          state_next = ST_STOP;
        else if (wait_exec_i)
          state_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (standby_exit)
          state_next = ST_RUN; // R9
      end
      ST_STOP:
      begin
        if (module_irq_i | break_req_i)
          state_next = ST_RECOVER; // R15
      end
      ST_RECOVER:
      begin
        if (sic_count_reg >= recovery_limit)
          state_next = ST_RUN;
      end
      default:
        state_next = ST_RUN;
    endcase
    if (any_reset)
      state_next = ST_RUN; // R15
  end

  // =============================================================
  // Sequencing registers
  // State, recovery counter, clock enables and CPU strobes.
  // Every enable is built from the next state, so the outputs change
  // on the same edge as the state and never lag it by a cycle.
  // The stacking strobe is a single-cycle pulse for the core.
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg           <= ST_RUN;
      sic_count_reg       <= 13'h0000;
      core_reset_reg      <= 1'b0;
      force_trap_reg      <= 1'b0;
      clear_imask_reg     <= 1'b0;
      stack_start_reg     <= 1'b0;
      stack_after_rec_reg <= 1'b0;
      break_req_d_reg     <= 1'b0;
      break_state_reg     <= 1'b0;
      cpu_clk_en_reg      <= 1'b1;
      periph_clk_en_reg   <= 1'b1;
      osc_en_reg          <= 1'b1;
      counter_hold_reg    <= 1'b0;
      watchdog_run_reg    <= 1'b0;
    end
    else
    begin
      state_reg       <= state_next;
      core_reset_reg  <= any_reset; // R2
      break_req_d_reg <= break_req_i;
      // A break forces the CPU to the trap vector, never during reset.
      force_trap_reg  <= break_rise & ~any_reset; // R3
      if (any_reset | break_exit_i)
        break_state_reg <= 1'b0;
      else if (break_rise)
        break_state_reg <= 1'b1; // R3
      // Entering either standby mode lets interrupts wake the CPU.
      clear_imask_reg <= (state_reg == ST_RUN) & (wait_exec_i | stop_exec_i) & ~any_reset; // R7
      // Wake from wait: stacking strobe follows one cycle later.
      stack_start_reg <= ~any_reset & (((state_reg == ST_WAIT) & (module_irq_i | break_req_i)) |
                         (stack_after_rec_reg & (state_next == ST_RUN) & (state_reg == ST_RECOVER))); // R10
      if (any_reset)
        stack_after_rec_reg <= 1'b0;
      else if ((state_reg == ST_STOP) & (state_next == ST_RECOVER))
        stack_after_rec_reg <= 1'b1; // R15
      else if (state_reg == ST_RUN)
        stack_after_rec_reg <= 1'b0;
      // Counter is held from stop entry until recovery, then counts quad cycles.
      if ((state_next == ST_STOP) | (state_next == ST_RUN) | (state_next == ST_WAIT))
        sic_count_reg <= 13'h0000; // R17
      else
        sic_count_reg <= sic_count_reg + QUAD_STEP; // R16
      counter_hold_reg  <= (state_next == ST_STOP); // R14
      cpu_clk_en_reg    <= (state_next == ST_RUN); // R8
      periph_clk_en_reg <= (state_next == ST_RUN) | (state_next == ST_WAIT); // R8
      osc_en_reg        <= (state_next != ST_STOP); // R14
      // Watchdog runs in run and wait when not disabled.
      watchdog_run_reg  <= ~watchdog_disable_i &
                           ((state_next == ST_RUN) | (state_next == ST_WAIT)); // R13
    end
  end

  // =============================================================
  // Software-visible registers
  // Flags, reset cause and APB handshake; a set wins over a clear.
  // The slave answers in the first access cycle with no wait state.
  // A read clears only the flags it returned; a cause that arrives on
  // the clearing edge stays set, so no reset can go unreported.
  // Writes to reserved bits and to unmapped words have no effect.
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      break_in_standby_reg   <= 1'b0;
      break_clear_enable_reg <= 1'b0;
      reset_cause_reg        <= `RST_RESET_CAUSE;
      mon_check_reg          <= 1'b0;
      mon_reset_reg          <= 1'b0;
      prdata_reg             <= 32'h00000000;
      pready_reg             <= 1'b0;
      pslverr_reg            <= 1'b0;
    end
    else
    begin
      pready_reg  <= setup_phase;
      pslverr_reg <= setup_phase & ~mapped;
      if (setup_phase)
        prdata_reg <= {24'h000000, read_byte};
      // Monitor entry is checked once after power-on releases.
      // The check uses the vector and the pin as they stand in the first
      // cycle after power-on falls; the resulting reset lasts one cycle.
      mon_reset_reg <= 1'b0;
      if (power_on_i)
        mon_check_reg <= 1'b1;
      else if (mon_check_reg)
      begin
        mon_check_reg <= 1'b0;
        mon_reset_reg <= (reset_vector_i == `MONITOR_VECTOR_ONES) & irq_pin_at_supply_i; // R21
      end
      // Power-on leaves only its own flag; other causes add theirs.
      if (power_on_i)
      begin
        reset_cause_reg <= 8'h00;
        reset_cause_reg[`BIT_POWER_ON] <= 1'b1; // R20
      end
      else if (access_done & ~pwrite_i & hit(paddr_i, `IDX_RESET_CAUSE))
        reset_cause_reg <= (reset_cause_reg & ~prdata_reg[7:0]) | cause_set; // R20
      else
        reset_cause_reg <= reset_cause_reg | cause_set; // R19
      // Break during wait marks the standby flag; writing zero clears it.
      if ((state_reg == ST_WAIT) & break_req_i)
        break_in_standby_reg <= 1'b1; // R12
      else if (access_done & pwrite_i & hit(paddr_i, `IDX_BREAK_STATUS) &
               ~pwdata_i[`BIT_BREAK_IN_STANDBY])
        break_in_standby_reg <= 1'b0;
      if (access_done & pwrite_i & hit(paddr_i, `IDX_BREAK_FLAG_CONTROL))
        break_clear_enable_reg <= pwdata_i[`BIT_BREAK_CLEAR_ENABLE];
    end
  end

  // =============================================================
  // Flag protection
  // Peripherals may finish a clear only when this is high; a cleared flag
  // is never restored, and a pending second step waits for it.
  // The output falls on the same edge as the break state rises, so a
  // clear that the core issues in its first break cycle is blocked.
  // It stays high through reset so peripherals start unprotected.
  reg flag_clear_allow_reg;
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      flag_clear_allow_reg <= 1'b1;
    else
      flag_clear_allow_reg <= ~((break_state_reg | break_rise) & ~any_reset) |
                              break_clear_enable_reg; // R4 R5 R6
  end

  // =============================================================
  // Outputs
  // Every output is a register; the two oscillator enables share one
  // flip-flop since stop is the only mode that halts them.
  assign prdata_o              = prdata_reg;
  assign pready_o              = pready_reg;
  assign pslverr_o             = pslverr_reg;
  assign core_reset_o          = core_reset_reg;
  assign force_trap_o          = force_trap_reg;
  assign break_state_o         = break_state_reg;
  assign flag_clear_allow_o    = flag_clear_allow_reg;
  assign clear_imask_o         = clear_imask_reg;
  assign cpu_clk_en_o          = cpu_clk_en_reg;
  assign periph_clk_en_o       = periph_clk_en_reg;
  assign bus_clock_double_en_o = osc_en_reg;
  assign bus_clock_quad_en_o   = osc_en_reg;
  assign counter_hold_o        = counter_hold_reg;
  assign stack_start_o         = stack_start_reg;
  assign watchdog_run_o        = watchdog_run_reg;

endmodule // standby_break_reset_status
`default_nettype wire

//--- tb/standby_break_reset_status_chk.sv
// Concurrent checks on the standby, break and reset-status unit.
`timescale 1ns/1ps
`default_nettype none
module standby_break_reset_status_chk #(
  parameter SHORT_RECOVERY_CYC = 32
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic power_on_i,
  input wire logic pin_reset_i,
  input wire logic watchdog_reset_i,
  input wire logic bad_opcode_i,
  input wire logic bad_address_i,
  input wire logic low_voltage_i,
  input wire logic break_req_i,
  input wire logic wait_exec_i,
  input wire logic stop_exec_i,
  input wire logic module_irq_i,
  input wire logic short_stop_recovery_i,
  input wire logic core_reset_o,
  input wire logic force_trap_o,
  input wire logic break_state_o,
  input wire logic flag_clear_allow_o,
  input wire logic clear_imask_o,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic bus_clock_double_en_o,
  input wire logic bus_clock_quad_en_o,
  input wire logic counter_hold_o,
  input wire logic stack_start_o
);
  localparam int S_LO = SHORT_RECOVERY_CYC / 4 - 1;
  localparam int S_HI = SHORT_RECOVERY_CYC / 4 + 2;
  logic in_wait;

  // ==========================================================
  // Wait tracking
  // Marks the core as waiting from an accepted wait until its clock returns.
  always_ff @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i)
      in_wait <= 1'b0;
    else
      in_wait <= (wait_exec_i && !stop_exec_i && cpu_clk_en_o) || (in_wait && !cpu_clk_en_o);

  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  // ==========================================================
  // Properties
  a_cause_reset: assert property (
    (power_on_i | pin_reset_i | watchdog_reset_i | bad_opcode_i | bad_address_i | low_voltage_i) |=> core_reset_o)
    else $error("reset cause gave no core reset");
  a_break_trap: assert property ($rose(break_req_i) |=> force_trap_o ##1 !force_trap_o)
    else $error("break request gave no single trap pulse");
  a_flag_protect: assert property (!flag_clear_allow_o |-> break_state_o || $past(break_state_o))
    else $error("flag clearing blocked outside break");
  a_standby_imask: assert property ((wait_exec_i || stop_exec_i) && cpu_clk_en_o |=> clear_imask_o)
    else $error("standby entry left the interrupt mask set");
  a_wait_clocks: assert property (wait_exec_i && !stop_exec_i && cpu_clk_en_o
    |=> !cpu_clk_en_o && periph_clk_en_o) else $error("wait entry clock gating wrong");
  a_wait_wake: assert property (in_wait && !cpu_clk_en_o && (module_irq_i || break_req_i)
    |=> cpu_clk_en_o && stack_start_o) else $error("wait wake or stacking late");
  a_stop_clocks: assert property (stop_exec_i && !wait_exec_i && cpu_clk_en_o |=>
    !bus_clock_double_en_o && !bus_clock_quad_en_o && !cpu_clk_en_o && counter_hold_o)
    else $error("stop entry left clocks running");
  a_short_recovery: assert property ($fell(counter_hold_o) && short_stop_recovery_i && !core_reset_o
    |-> ##[S_LO:S_HI] stack_start_o) else $error("short stop recovery length wrong");
endmodule // standby_break_reset_status_chk

bind standby_break_reset_status standby_break_reset_status_chk #(.SHORT_RECOVERY_CYC(SHORT_RECOVERY_CYC)) chk (
  .clock_i, .arst_n_i, .power_on_i, .pin_reset_i, .watchdog_reset_i, .bad_opcode_i, .bad_address_i,
  .low_voltage_i, .break_req_i, .wait_exec_i, .stop_exec_i, .module_irq_i, .short_stop_recovery_i, .core_reset_o,
  .force_trap_o, .break_state_o, .flag_clear_allow_o, .clear_imask_o, .cpu_clk_en_o, .periph_clk_en_o,
  .bus_clock_double_en_o, .bus_clock_quad_en_o, .counter_hold_o, .stack_start_o);
`default_nettype wire

//--- tb/core_model.sv
// Behavioural CPU core and peripheral event source.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic clock_i,
  output logic      break_req_o,
  output logic      break_exit_o,
  output logic      wait_exec_o,
  output logic      stop_exec_o,
  output logic      module_irq_o,
  output logic      convert_done_o,
  output logic      short_recovery_o
);
  // ==========================================================
  // Event drivers
  // Full recovery delay by default, as a crystal-timed system needs.
  initial
  begin
    {short_recovery_o, break_req_o, module_irq_o, convert_done_o} = 4'h0;
    {break_exit_o, wait_exec_o, stop_exec_o} = 3'h0;
  end

  // Sets the level requests after an edge; gap cycles model a slow core.
  task automatic level(input logic [3:0] l, input int gap = 0);
    repeat (gap + 1) @(posedge clock_i);
    {short_recovery_o, break_req_o, module_irq_o, convert_done_o} <= l;
  endtask

  // Issues one-cycle instruction events: break exit, wait, stop.
  task automatic pulse(input logic [2:0] p);
    @(posedge clock_i);
    {break_exit_o, wait_exec_o, stop_exec_o} <= p;
    @(posedge clock_i);
    {break_exit_o, wait_exec_o, stop_exec_o} <= 3'h0;
  endtask
endmodule // core_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the standby, break and reset-status unit.
`timescale 1ns/1ps
`default_nettype none
`include "standby_break_reset_status_defs.vh"
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); end end
module testbench;
  logic        clock_i, arst_n_i, psel_i, penable_i, pwrite_i, irq_pin_at_supply_i, watchdog_disable_i;
  logic [31:0] paddr_i, pwdata_i;
  logic [15:0] reset_vector_i;
  logic [31:0] r;
  logic [5:0]  causes;
  logic [32:0] e, exp_q[$];
  logic [7:0]  cexp[5] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h02};
  int          fail_count, tests_run, n;
  wire  [31:0] prdata_o;
  wire         power_on_i, pin_reset_i, watchdog_reset_i, bad_opcode_i, bad_address_i, low_voltage_i;
  wire         break_req_i, break_exit_i, wait_exec_i, stop_exec_i, module_irq_i, convert_done_req_i;
  wire         short_stop_recovery_i, pready_o, pslverr_o, core_reset_o, force_trap_o, break_state_o;
  wire         flag_clear_allow_o, clear_imask_o, cpu_clk_en_o, periph_clk_en_o, bus_clock_double_en_o;
  wire         bus_clock_quad_en_o, counter_hold_o, stack_start_o, watchdog_run_o;
  assign {power_on_i, pin_reset_i, watchdog_reset_i, bad_opcode_i, bad_address_i, low_voltage_i} = causes;

  standby_break_reset_status #(.LONG_RECOVERY_CYC(64), .SHORT_RECOVERY_CYC(32)) uut (
    .clock_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .power_on_i, .pin_reset_i, .watchdog_reset_i, .bad_opcode_i, .bad_address_i, .low_voltage_i, .reset_vector_i,
    .irq_pin_at_supply_i, .break_req_i, .break_exit_i, .wait_exec_i, .stop_exec_i, .module_irq_i,
    .convert_done_req_i, .watchdog_disable_i, .short_stop_recovery_i, .core_reset_o, .force_trap_o, .break_state_o,
    .flag_clear_allow_o, .clear_imask_o, .cpu_clk_en_o, .periph_clk_en_o, .bus_clock_double_en_o,
    .bus_clock_quad_en_o, .counter_hold_o, .stack_start_o, .watchdog_run_o);
  core_model core (.clock_i, .break_req_o(break_req_i), .break_exit_o(break_exit_i), .wait_exec_o(wait_exec_i),
    .stop_exec_o(stop_exec_i), .module_irq_o(module_irq_i), .convert_done_o(convert_done_req_i),
    .short_recovery_o(short_stop_recovery_i));

  // ==========================================================
  // Shared tasks
  task automatic give_verdict();
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic timeout();
    fail_count++;
    give_verdict();
  endtask
  // One APB transfer; a read notes its expected {error, data} for the monitor.
  task automatic apb(input logic [15:0] idx, input logic wr, input logic [7:0] wd, input logic [32:0] x);
    int k;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= {14'h0000, idx, 2'b00};
    pwdata_i <= {24'h000000, wd};
    if (!wr) exp_q.push_back(x);
    @(posedge clock_i);
    penable_i <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock_i);
      k++;
      if (k > 20) timeout();
    end
    while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic cause_pulse(input logic [5:0] c);
    @(posedge clock_i);
    causes <= c;
    @(posedge clock_i);
    causes <= 6'h00;
  endtask
  task automatic wait_stack(output int c);
    c = 0;
    do
    begin
      @(posedge clock_i);
      c++;
      if (c > 500) timeout();
    end
    while (stack_start_o !== 1'b1);
  endtask

  // Clock generation.
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Compares each completed read with the oldest noted expectation.
  always @(posedge clock_i)
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      `CHK({pslverr_o, prdata_o}, e)
    end

  // ==========================================================
  // Main sequence
  initial
  begin
    {arst_n_i, psel_i, penable_i, pwrite_i, watchdog_disable_i} = 5'h00;
    {paddr_i, pwdata_i} = 64'h0;
    causes = 6'h00;
    reset_vector_i = 16'hffff;
    irq_pin_at_supply_i = 1'b1;
    fail_count = 0;
    tests_run = 0;
    n = $urandom(32'hc46e7d3b);
    r = $urandom;
    watchdog_disable_i <= r[8];
    repeat (3) @(posedge clock_i);
    arst_n_i <= 1'b1;
    cause_pulse(6'h20);
    repeat (3) @(posedge clock_i);
    apb(`IDX_RESET_CAUSE, 0, 8'h00, 33'h084);
    apb(`IDX_RESET_CAUSE, 0, 8'h00, 33'h000);
    `CHK(watchdog_run_o, ~watchdog_disable_i)
    // Causes in a random rotation, each read back and cleared on its own.
    for (int i = 0; i < 5; i++)
    begin
      cause_pulse(6'h10 >> ((i + r[7:0]) % 5));
      apb(`IDX_RESET_CAUSE, 0, 8'h00, {25'h0, cexp[(i + r[7:0]) % 5]});
    end
    reset_vector_i <= r[9] ? 16'hffff : (r[31:16] & 16'hfffe);
    irq_pin_at_supply_i <= r[10];
    cause_pulse(6'h10);
    cause_pulse(6'h20);
    repeat (3) @(posedge clock_i);
    apb(`IDX_RESET_CAUSE, 0, 8'h00, {25'h0, 1'b1, 4'h0, r[9] & r[10], 2'b00});
    core.level({3'b000, r[11]});
    apb(`IDX_CONV_PENDING, 0, 8'h00, {32'h0, r[11]});
    core.level({3'b000, ~r[11]});
    apb(`IDX_CONV_PENDING, 0, 8'h00, {32'h0, ~r[11]});
    apb(16'hfe02, 0, 8'h00, 33'h100000000);
    apb(`IDX_BREAK_FLAG_CONTROL, 0, 8'h00, 33'h000);
    // Break with clearing blocked, then enabled, then left.
    core.level(4'b0100);
    repeat (2) @(negedge clock_i);
    `CHK({break_state_o, flag_clear_allow_o}, 2'b10)
    apb(`IDX_BREAK_FLAG_CONTROL, 1, 8'h80, 33'h000);
    apb(`IDX_BREAK_FLAG_CONTROL, 0, 8'h00, 33'h080);
    @(negedge clock_i);
    `CHK(flag_clear_allow_o, 1'b1)
    apb(`IDX_BREAK_FLAG_CONTROL, 1, 8'h00, 33'h000);
    core.pulse(3'b100);
    core.level(4'b0000);
    repeat (2) @(negedge clock_i);
    `CHK({break_state_o, flag_clear_allow_o}, 2'b01)
    // Wait woken by break, then by a late module interrupt.
    core.pulse(3'b010);
    @(negedge clock_i);
    `CHK({cpu_clk_en_o, periph_clk_en_o, watchdog_run_o}, {2'b01, ~watchdog_disable_i})
    core.level(4'b0100);
    wait_stack(n);
    apb(`IDX_BREAK_STATUS, 0, 8'h00, 33'h002);
    apb(`IDX_BREAK_STATUS, 1, 8'h00, 33'h000);
    apb(`IDX_BREAK_STATUS, 0, 8'h00, 33'h000);
    core.pulse(3'b100);
    core.level(4'b0000);
    core.pulse(3'b010);
    core.level(4'b0010, 3);
    wait_stack(n);
    `CHK(n, 2)
    core.level(4'b0000);
    // Stop with long and short recovery.
    for (int s = 0; s < 2; s++)
    begin
      core.level({s[0], 3'b000});
      core.pulse(3'b001);
      @(negedge clock_i);
      `CHK({bus_clock_double_en_o, bus_clock_quad_en_o, counter_hold_o}, 3'b001)
      core.level({s[0], 3'b010}, 5);
      wait_stack(n);
      `CHK(n, (s ? 32 : 64) / 4 + 2)
      core.level(4'b0000);
    end
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
